// >>> seic_map.svh
// timing counts, scaling factors and per-period limits of the secondary encoder input
//
// Notes on behaviour
// - count edges, sample counter every servo period
// - scale counts, carry fractional remainder forward
// - clamp per-period counts, carry excess forward
// - quadrature counts every edge of both channels
// - leading channel sets quadrature count direction
// - one index pulse per index position
// - every step pulse counts, spurious included
// - quadrature filter rejects short glitches
// - reduced variant lacks step up/down
// - plain output quadrature, modulo output any format
// - scale 1..32767, base value means 1:1
`ifndef SEIC_MAP_SVH
`define SEIC_MAP_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SEIC_CLK_NS      40
`define SEIC_PERIOD_NS   120000
`define SEIC_PERIOD_CYC  (`SEIC_PERIOD_NS / `SEIC_CLK_NS)
`define SEIC_FILT_CYC    2'h3
`define SEIC_STEP_GAP    6'h28
`define SEIC_STEP_HALF   6'h14

// ----------------------------------------------------------------------
// scaling and limits
// ----------------------------------------------------------------------
`define SEIC_FRAC_W      10
`define SEIC_SCALE_MAX   15'h7FFF
`define SEIC_SCALE_MIN   15'h0001
`define SEIC_MAX_POS     24'sh00001F
`define SEIC_MAX_NEG     24'shFFFFE0

`endif

// >>> seic_pkg.sv
// types shared by the secondary encoder input logic
package seic_pkg;

  typedef enum logic [1:0] {
    SEIC_FMT_SD,
    SEIC_FMT_UD,
    SEIC_FMT_QUAD
  } seic_fmt_t;

  typedef logic signed [15:0] seic_cnt_t;
  typedef logic signed [23:0] seic_acc_t;

endpackage

// >>> seic_counter.sv
// secondary encoder input counter, scaler and encoder output generator
`timescale 1ns/100ps
`include "seic_map.svh"

module seic_counter
  import seic_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  input  wire logic               enc_a_i,
  input  wire logic               enc_b_i,
  input  wire logic               enc_idx_i,
  input  wire seic_fmt_t          in_fmt_i,
  input  wire logic               full_variant_i,
  input  wire logic        [15:0] scale_i,
  input  wire seic_fmt_t          out_fmt_i,
  output logic                    servo_tick_o,
  output logic signed      [5:0]  motion_cnt_o,
  output logic                    motion_vld_o,
  output logic signed      [31:0] motion_pos_o,
  output logic                    index_o,
  output logic                    fmt_err_o,
  output logic                    enc_out_a_o,
  output logic                    enc_out_b_o,
  output logic                    enc_out_idx_o,
  output logic                    mod_out_a_o,
  output logic                    mod_out_b_o
);

  // ----------------------------------------------------------------------
  // servo period divider
  // ----------------------------------------------------------------------
  localparam logic [11:0] PERIOD_LAST = 12'(`SEIC_PERIOD_CYC - 1);

  logic [11:0] div_cnt;
  wire         tick = (div_cnt == PERIOD_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || tick) begin
      div_cnt <= 12'h000;
    end else begin
      div_cnt <= div_cnt + 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  // step formats see the raw lines so no pulse is dropped; quadrature
  // sees the filtered copy so a short glitch never reaches the decoder
  wire  [2:0] raw = {enc_idx_i, enc_b_i, enc_a_i};
  logic [2:0] raw_q;
  logic [2:0] filt;
  logic [2:0] filt_q;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_filt
      logic [1:0] stab;
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          stab     <= 2'h0;
          filt[ch] <= 1'b0;
        end else if (raw[ch] == filt[ch]) begin
          stab <= 2'h0;
        end else if (stab == `SEIC_FILT_CYC - 2'h1) begin
          stab     <= 2'h0;
          filt[ch] <= raw[ch];
        end else begin
          stab <= stab + 2'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      raw_q  <= 3'h0;
      filt_q <= 3'h0;
    end else begin
      raw_q  <= raw;
      filt_q <= filt;
    end
  end

  // ----------------------------------------------------------------------
  // format decode
  // ----------------------------------------------------------------------
  wire a_rise   = raw[0] & ~raw_q[0];
  wire b_rise   = raw[1] & ~raw_q[1];
  wire fmt_sd   = (in_fmt_i == SEIC_FMT_SD);
  wire fmt_ud   = (in_fmt_i == SEIC_FMT_UD) & full_variant_i;
  wire fmt_quad = (in_fmt_i == SEIC_FMT_QUAD);
  wire fmt_ok   = fmt_sd | fmt_ud | fmt_quad;

  // a single changed channel is one quarter step; both at once is illegal
  wire q_chg = (filt[0] ^ filt_q[0]) ^ (filt[1] ^ filt_q[1]);
  wire q_fwd = filt_q[0] ^ filt[1];

  wire sd_up = a_rise & raw[1];
  wire sd_dn = a_rise & ~raw[1];
  wire ud_up = a_rise & ~b_rise;
  wire ud_dn = b_rise & ~a_rise;

  wire cnt_up = (fmt_sd & sd_up) | (fmt_ud & ud_up) | (fmt_quad & q_chg & q_fwd);
  wire cnt_dn = (fmt_sd & sd_dn) | (fmt_ud & ud_dn) | (fmt_quad & q_chg & ~q_fwd);

  // index uses the filtered line in quadrature, the raw line otherwise
  wire idx_now  = fmt_quad ? filt[2] : raw[2];
  wire idx_prev = fmt_quad ? filt_q[2] : raw_q[2];
  wire idx_rise = idx_now & ~idx_prev & fmt_ok;

  // ----------------------------------------------------------------------
  // free running edge counter and period sampling
  // ----------------------------------------------------------------------
  seic_cnt_t hw_cnt;
  seic_cnt_t last_smp;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hw_cnt <= 16'sh0000;
    end else if (cnt_up) begin
      hw_cnt <= hw_cnt + 16'sh0001;
    end else if (cnt_dn) begin
      hw_cnt <= hw_cnt - 16'sh0001;
    end
  end

  // difference of two samples wraps cleanly while the rate stays in range
  wire seic_cnt_t smp_diff = hw_cnt - last_smp;

  // ----------------------------------------------------------------------
  // scaling with fractional carry
  // ----------------------------------------------------------------------
  logic [`SEIC_FRAC_W-1:0] frac;
  seic_acc_t               backlog;

  wire [14:0] scale_lo  = scale_i[14:0];
  wire [14:0] scale_eff = (scale_lo < `SEIC_SCALE_MIN) ? `SEIC_SCALE_MIN
                                                        : (scale_lo & `SEIC_SCALE_MAX);

  wire signed [31:0] prod  = 32'(smp_diff) * $signed({17'h00000, scale_eff});
  wire signed [31:0] total = prod + $signed({22'h000000, frac});
  wire signed [21:0] whole = total[31:`SEIC_FRAC_W];

  // ----------------------------------------------------------------------
  // per-period limit with excess carried forward
  // ----------------------------------------------------------------------
  wire seic_acc_t pend    = backlog + {{2{whole[21]}}, whole};
  wire            too_hi  = (pend > `SEIC_MAX_POS);
  wire            too_lo  = (pend < `SEIC_MAX_NEG);
  wire seic_acc_t applied = too_hi ? `SEIC_MAX_POS : (too_lo ? `SEIC_MAX_NEG : pend);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      last_smp <= 16'sh0000;
      frac     <= '0;
      backlog  <= 24'sh000000;
    end else if (tick) begin
      last_smp <= hw_cnt;
      frac     <= total[`SEIC_FRAC_W-1:0];
      backlog  <= pend - applied;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      motion_cnt_o <= 6'sh00;
      motion_vld_o <= 1'b0;
      motion_pos_o <= 32'sh00000000;
      servo_tick_o <= 1'b0;
    end else begin
      servo_tick_o <= tick;
      motion_vld_o <= tick;
      if (tick) begin
        motion_cnt_o <= applied[5:0];
        motion_pos_o <= motion_pos_o + {{8{applied[23]}}, applied};
      end
    end
  end

  // ----------------------------------------------------------------------
  // status and index
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fmt_err_o <= 1'b0;
      index_o   <= 1'b0;
    end else begin
      fmt_err_o <= ~fmt_ok;
      index_o   <= idx_rise;
    end
  end

  // ----------------------------------------------------------------------
  // encoder output generator
  // ----------------------------------------------------------------------
  // replays the applied counts one step per gap; 75 steps fit a period
  logic signed [7:0] out_pend;
  logic        [5:0] gap_cnt;
  logic        [1:0] qpos;
  logic              step_act;
  logic              dir_out;

  wire       emit     = (gap_cnt == 6'h00) & (out_pend != 8'sh00);
  wire       emit_fwd = ~out_pend[7];
  wire [7:0] tick_add = tick ? applied[7:0] : 8'h00;
  wire [7:0] emit_sub = emit ? (emit_fwd ? 8'h01 : 8'hFF) : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      out_pend <= 8'sh00;
      gap_cnt  <= 6'h00;
      qpos     <= 2'h0;
      step_act <= 1'b0;
      dir_out  <= 1'b1;
    end else begin
      out_pend <= out_pend + $signed(tick_add) - $signed(emit_sub);
      if (emit) begin
        gap_cnt  <= `SEIC_STEP_GAP - 6'h01;
        step_act <= 1'b1;
        dir_out  <= emit_fwd;
        qpos     <= emit_fwd ? qpos + 2'h1 : qpos - 2'h1;
      end else begin
        if (gap_cnt != 6'h00) begin
          gap_cnt <= gap_cnt - 6'h01;
        end
        if (gap_cnt == `SEIC_STEP_HALF) begin
          step_act <= 1'b0;
        end
      end
    end
  end

  // gray sequence 00,01,11,10 going forward
  wire q_a = qpos[1];
  wire q_b = qpos[1] ^ qpos[0];

  wire mod_a = (out_fmt_i == SEIC_FMT_SD) ? step_act
             : (out_fmt_i == SEIC_FMT_UD) ? (step_act & dir_out) : q_a;
  wire mod_b = (out_fmt_i == SEIC_FMT_SD) ? dir_out
             : (out_fmt_i == SEIC_FMT_UD) ? (step_act & ~dir_out) : q_b;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      enc_out_a_o   <= 1'b0;
      enc_out_b_o   <= 1'b0;
      enc_out_idx_o <= 1'b0;
      mod_out_a_o   <= 1'b0;
      mod_out_b_o   <= 1'b0;
    end else begin
      enc_out_a_o   <= q_a;
      enc_out_b_o   <= q_b;
      enc_out_idx_o <= idx_rise;
      mod_out_a_o   <= mod_a;
      mod_out_b_o   <= mod_b;
    end
  end

endmodule

// >>> seic_counter_checker.sv
// assertion checker for the secondary encoder input counter
`timescale 1ns/100ps
module seic_counter_checker
  import seic_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               sys_rst_i,
  input wire seic_fmt_t          in_fmt_i,
  input wire logic               full_variant_i,
  input wire seic_fmt_t          out_fmt_i,
  input wire logic               servo_tick_o,
  input wire logic signed [5:0]  motion_cnt_o,
  input wire logic               motion_vld_o,
  input wire logic signed [31:0] motion_pos_o,
  input wire logic               index_o,
  input wire logic               fmt_err_o,
  input wire logic               enc_out_a_o,
  input wire logic               enc_out_b_o,
  input wire logic               mod_out_a_o,
  input wire logic               mod_out_b_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // cycles since the last tick; first tick has no reference
  logic [11:0] gap;
  logic        seen;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || servo_tick_o) begin
      gap <= 12'h000;
    end else begin
      gap <= gap + 12'h001;
    end
    seen <= !sys_rst_i && (seen || servo_tick_o);
  end
  a_tick_period: assert property (servo_tick_o && seen |-> gap == 12'hBB7)
    else $error("servo period not 3000 cycles");
  a_vld_tick: assert property (motion_vld_o == servo_tick_o)
    else $error("motion valid apart from tick");
  a_pos_sum: assert property (motion_vld_o |-> motion_pos_o == $past(motion_pos_o) + 32'(motion_cnt_o))
    else $error("position not advanced by applied counts");
  a_pos_hold: assert property (!motion_vld_o |-> $stable(motion_pos_o))
    else $error("position moved between periods");
  a_cnt_hold: assert property (!motion_vld_o |-> $stable(motion_cnt_o))
    else $error("applied counts changed between periods");
  a_index_once: assert property (index_o |=> !index_o)
    else $error("index pulse longer than one cycle");
  a_fmt_legal: assert property (!$past(sys_rst_i) && $stable(in_fmt_i) && $stable(full_variant_i)
    |-> fmt_err_o == (in_fmt_i == 2'h3 || (in_fmt_i == SEIC_FMT_UD && !full_variant_i)))
    else $error("format error flag wrong");
  a_plain_quad: assert property (!($changed(enc_out_a_o) && $changed(enc_out_b_o)))
    else $error("plain output not quadrature");
  a_mod_quad: assert property (out_fmt_i == SEIC_FMT_QUAD && $stable(out_fmt_i) && $past(out_fmt_i, 2) == SEIC_FMT_QUAD
    |-> !($changed(mod_out_a_o) && $changed(mod_out_b_o)))
    else $error("modulo output not quadrature");
endmodule

// >>> seic_enc_model.sv
// encoder and step pulse source feeding the counter inputs
`timescale 1ns/100ps
module seic_enc_model (
  input  wire logic clk_i,
  output logic      a_o,
  output logic      b_o,
  output logic      idx_o
);
  logic [1:0] q = 2'h0;
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
    idx_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // direction settles a cycle ahead of the step edge
  task automatic sd_step(input logic fwd);
    b_o = fwd;
    tick(1);
    a_o = 1'b1;
    tick(1);
    a_o = 1'b0;
    tick(1);
  endtask
  task automatic ud_step(input logic fwd);
    if (fwd) a_o = 1'b1;
    else b_o = 1'b1;
    tick(1);
    a_o = 1'b0;
    b_o = 1'b0;
    tick(1);
  endtask
  // gray order 00,01,11,10; each state held past the filter
  task automatic qd_step(input logic fwd);
    q = fwd ? q + 2'h1 : q - 2'h1;
    a_o = q[1];
    b_o = q[1] ^ q[0];
    tick(4);
  endtask
  task automatic glitch(input int n);
    a_o = ~a_o;
    tick(n);
    a_o = ~a_o;
    tick(4);
  endtask
  task automatic idx_pulse;
    // held past the quadrature filter so the index is accepted in every legal format
    idx_o = 1'b1;
    tick(4);
    idx_o = 1'b0;
    tick(1);
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the secondary encoder input counter
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %0d want %0d", $time, g, e); end end
module tb;
  import seic_pkg::*;
  logic               clk_sys_i, sys_rst_i, enc_a_i, enc_b_i, enc_idx_i, full_variant_i;
  logic        [15:0] scale_i;
  seic_fmt_t          in_fmt_i, out_fmt_i;
  logic               servo_tick_o, motion_vld_o, index_o, fmt_err_o, enc_out_idx_o;
  logic               enc_out_a_o, enc_out_b_o, mod_out_a_o, mod_out_b_o;
  logic signed [5:0]  motion_cnt_o;
  logic signed [31:0] motion_pos_o, p0;
  int                 mismatches = 0, cmp_count = 0, hits;
  seic_counter dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
    .enc_idx_i(enc_idx_i), .in_fmt_i(in_fmt_i), .full_variant_i(full_variant_i), .scale_i(scale_i),
    .out_fmt_i(out_fmt_i), .servo_tick_o(servo_tick_o), .motion_cnt_o(motion_cnt_o),
    .motion_vld_o(motion_vld_o), .motion_pos_o(motion_pos_o), .index_o(index_o), .fmt_err_o(fmt_err_o),
    .enc_out_a_o(enc_out_a_o), .enc_out_b_o(enc_out_b_o), .enc_out_idx_o(enc_out_idx_o),
    .mod_out_a_o(mod_out_a_o), .mod_out_b_o(mod_out_b_o));
  seic_enc_model enc_u (.clk_i(clk_sys_i), .a_o(enc_a_i), .b_o(enc_b_i), .idx_o(enc_idx_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_vld;
    int n;
    n = 0;
    while (motion_vld_o !== 1'b1) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 3100) begin
        mismatches++;
        report_and_stop();
      end
    end
    @(posedge clk_sys_i);
    #2;
  endtask
  // two periods let a backlog within one period limit drain before the delta is read
  task automatic settle;
    wait_vld();
    wait_vld();
  endtask
  task automatic t_quad;
    p0 = motion_pos_o;
    repeat (7) enc_u.qd_step(1'b1);
    repeat (3) enc_u.qd_step(1'b0);
    enc_u.glitch(2);
    enc_u.glitch(6);
    settle();
    `CHK(motion_pos_o - p0, 32'sd4)
    `CHK(enc_out_a_o, 1'b0)
    `CHK(enc_out_b_o, 1'b0)
  endtask
  task automatic t_step;
    in_fmt_i = SEIC_FMT_SD;
    out_fmt_i = SEIC_FMT_SD;
    p0 = motion_pos_o;
    repeat (5) enc_u.sd_step(1'b1);
    repeat (2) enc_u.sd_step(1'b0);
    settle();
    `CHK(motion_pos_o - p0, 32'sd3)
    `CHK(mod_out_b_o, 1'b1)
    scale_i = 16'h0800;
    p0 = motion_pos_o;
    repeat (3) enc_u.sd_step(1'b1);
    settle();
    `CHK(motion_pos_o - p0, 32'sd6)
    scale_i = 16'h0200;
    p0 = motion_pos_o;
    repeat (4) enc_u.sd_step(1'b1);
    settle();
    `CHK(motion_pos_o - p0, 32'sd2)
    scale_i = 16'h0400;
  endtask
  task automatic t_burst;
    wait_vld();
    repeat (40) enc_u.sd_step(1'b1);
    wait_vld();
    `CHK(motion_cnt_o, 6'sd31)
    wait_vld();
    `CHK(motion_cnt_o, 6'sd9)
  endtask
  task automatic t_updown;
    in_fmt_i = SEIC_FMT_UD;
    p0 = motion_pos_o;
    repeat (4) enc_u.ud_step(1'b1);
    enc_u.ud_step(1'b0);
    settle();
    `CHK(motion_pos_o - p0, 32'sd3)
    full_variant_i = 1'b0;
    p0 = motion_pos_o;
    repeat (2) enc_u.ud_step(1'b1);
    `CHK(fmt_err_o, 1'b1)
    settle();
    `CHK(motion_pos_o - p0, 32'sd0)
    full_variant_i = 1'b1;
    in_fmt_i = SEIC_FMT_QUAD;
  endtask
  task automatic t_index;
    hits = 0;
    fork
      enc_u.idx_pulse();
      repeat (12) begin
        @(posedge clk_sys_i);
        #1;
        hits += (index_o === 1'b1 && enc_out_idx_o === 1'b1);
      end
    join
    `CHK(hits, 1)
  endtask
  initial begin
    sys_rst_i = 1'b1;
    in_fmt_i = SEIC_FMT_QUAD;
    out_fmt_i = SEIC_FMT_QUAD;
    full_variant_i = 1'b1;
    scale_i = 16'h0400;
    repeat (16) @(posedge clk_sys_i);
    #2;
    sys_rst_i = 1'b0;
    t_quad();
    t_index();
    t_step();
    t_burst();
    t_updown();
    report_and_stop();
  end
endmodule
bind seic_counter seic_counter_checker chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .in_fmt_i(in_fmt_i), .full_variant_i(full_variant_i), .out_fmt_i(out_fmt_i), .servo_tick_o(servo_tick_o),
  .motion_cnt_o(motion_cnt_o), .motion_vld_o(motion_vld_o), .motion_pos_o(motion_pos_o), .index_o(index_o),
  .fmt_err_o(fmt_err_o), .enc_out_a_o(enc_out_a_o), .enc_out_b_o(enc_out_b_o), .mod_out_a_o(mod_out_a_o),
  .mod_out_b_o(mod_out_b_o));
